// *** hdl/cbmd_pkg.sv ***
// Constants for the chip-mode and bus-mode address decoder.
// Assumes a 22-bit physical address from the core and 25 shared bus pins.
package cbmd_pkg;

  localparam int unsigned CBMD_ADDR_W = 22;
  localparam int unsigned CBMD_PIN_ADDR_W = 19;
  localparam int unsigned CBMD_PORT_W = 34;
  localparam int unsigned CBMD_CS_N = 4;

  // Internal page (RAM, display, I/O) that never goes outside.
  localparam logic [9:0] CBMD_INT_PAGE = 10'h00F;
  // First address above the on-chip program memory.
  localparam logic [21:0] CBMD_PROM_TOP = 22'h00_F000;
  // Top of the lowest 64K physical range.
  localparam logic [21:0] CBMD_LOW64_TOP = 22'h01_0000;
  // External window of the 512K modes, released and internal program.
  localparam logic [21:0] CBMD_REL_EXT_TOP = 22'h20_0000;
  localparam logic [21:0] CBMD_INT_EXT_BOT = 22'h08_0000;
  localparam logic [21:0] CBMD_INT_EXT_TOP = 22'h28_0000;

  // Software encoding of the bus mode request.
  localparam logic [1:0] CBMD_SEL_SINGLE = 2'h0;
  localparam logic [1:0] CBMD_SEL_EXP64 = 2'h1;
  localparam logic [1:0] CBMD_SEL_MIN512 = 2'h2;
  localparam logic [1:0] CBMD_SEL_MAX512 = 2'h3;

  // Chip-select range size in expanded 64K mode.
  localparam logic [1:0] CBMD_SZ_8K = 2'h0;
  localparam logic [1:0] CBMD_SZ_16K = 2'h1;
  localparam logic [1:0] CBMD_SZ_32K = 2'h2;
  localparam logic [1:0] CBMD_SZ_64K = 2'h3;
  localparam logic [1:0] CBMD_SZ_RST = 2'h3;

  // Positions of the shared strobes and the general-purpose bits inside the output port word.
  localparam int unsigned CBMD_PORT_RD = 19;
  localparam int unsigned CBMD_PORT_WR = 20;
  localparam int unsigned CBMD_PORT_CS_LSB = 21;
  localparam int unsigned CBMD_PORT_GP_LSB = 25;

  // Cycles the strap synchroniser needs before its output is trusted.
  localparam logic [1:0] CBMD_SETTLE_CNT = 2'h3;

  typedef enum logic [3:0] {
    CBMD_BM_SINGLE = 4'b0001,
    CBMD_BM_EXP64 = 4'b0010,
    CBMD_BM_MIN512 = 4'b0100,
    CBMD_BM_MAX512 = 4'b1000
  } cbmd_bus_mode_t;

endpackage

// *** hdl/cbmd_pin_sync.sv ***
// Three-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to core_clk_i; reset value is the pulled level.
`timescale 1ns/10ps
module cbmd_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic agree_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } cbmd_sync_t;

  cbmd_sync_t st_r;
  cbmd_sync_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // The first stage is read only by the second one.
  assign level_o = st_r.s3;
  assign agree_o = (st_r.s2 == st_r.s3);

endmodule // cbmd_pin_sync

// *** hdl/cbmd_top.sv ***
// Chip-mode strap capture, bus-mode selection and external address decode.
// Assumes the core presents a physical address with level read and write
// requests, and the pad ring resolves pins from the output enables.
`timescale 1ns/10ps
module cbmd_top
  import cbmd_pkg::*;
#(
  parameter int unsigned ADDR_W = CBMD_ADDR_W
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic program_source_select_pin_i,
  output logic mode_pin_pullup_en_o,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_int_sel_o,
  input wire logic bus_mode_wr_i,
  input wire logic [1:0] bus_mode_sel_i,
  input wire logic [1:0] cs_size_i,
  input wire logic [CBMD_CS_N-1:0] cs_pin_en_i,
  input wire logic [CBMD_PORT_W-1:0] port_out_i,
  input wire logic [7:0] port_data_i,
  input wire logic [7:0] port_dir_i,
  output logic mode_ready_o,
  output logic released_program_mode_o,
  output logic [1:0] bus_mode_o,
  output logic core_max_model_o,
  output logic bus_ports_mode_o,
  output logic [CBMD_PIN_ADDR_W-1:0] addr_pin_o,
  output logic rd_n_pin_o,
  output logic wr_n_pin_o,
  output logic [CBMD_CS_N-1:0] cs_n_pin_o,
  output logic [CBMD_PORT_W-CBMD_PORT_GP_LSB-1:0] gp_port_o,
  input wire logic [7:0] external_data_lines_i,
  output logic [7:0] external_data_lines_o,
  output logic [7:0] external_data_lines_oe_o,
  output logic [7:0] external_data_lines_pu_o
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic strapped;
    logic released;
    logic [1:0] settle;
    cbmd_bus_mode_t bus_mode;
    logic [1:0] cs_size;
    logic [CBMD_CS_N-1:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] dat_out;
    logic [7:0] dat_oe;
    logic [7:0] rdata;
    logic int_sel;
    logic [CBMD_PIN_ADDR_W-1:0] addr_pin;
  } cbmd_state_t;

  localparam cbmd_state_t CBMD_STATE_RST = '{
    strapped: 1'b0,
    released: 1'b0,
    settle: 2'h0,
    bus_mode: CBMD_BM_SINGLE,
    cs_size: CBMD_SZ_RST,
    cs_n: {CBMD_CS_N{1'b1}},
    rd_n: 1'b1,
    wr_n: 1'b1,
    dat_out: 8'h00,
    dat_oe: 8'h00,
    rdata: 8'h00,
    int_sel: 1'b0,
    addr_pin: {CBMD_PIN_ADDR_W{1'b0}}
  };

  cbmd_state_t st_r;
  cbmd_state_t st_nxt;

  logic pin_level;
  logic pin_agree;

  logic [21:0] addr;
  logic int_page;
  logic prom_hit;
  logic ext_hit;
  logic [1:0] cs_idx;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin.

  cbmd_pin_sync #(
    .RST_VAL(1'b1)
  ) u_mode_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(program_source_select_pin_i),
    .level_o(pin_level),
    .agree_o(pin_agree)
  );

  // The pad pull-up stays on so that an open pin reads high.
  assign mode_pin_pullup_en_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  assign addr = 22'(cpu_addr_i);
  assign access = st_r.strapped && (cpu_rd_i || cpu_wr_i);

  always_comb
  begin
    int_page = (addr[21:12] == CBMD_INT_PAGE);
    // On-chip program memory answers only when the strap says so.
    prom_hit = !st_r.released && (addr < CBMD_PROM_TOP);
    ext_hit = 1'b0;
    cs_idx = 2'h0;
    unique case (st_r.bus_mode)
      CBMD_BM_SINGLE:
      begin
        ext_hit = 1'b0;
      end
      CBMD_BM_EXP64:
      begin
        if (addr < CBMD_LOW64_TOP)
        begin
          unique case (st_r.cs_size)
            CBMD_SZ_8K:
            begin
              ext_hit = !addr[15];
              cs_idx = addr[14:13];
            end
            CBMD_SZ_16K:
            begin
              ext_hit = 1'b1;
              cs_idx = addr[15:14];
            end
            CBMD_SZ_32K:
            begin
              ext_hit = 1'b1;
              cs_idx = {1'b0, addr[15]};
            end
            default:
            begin
              ext_hit = 1'b1;
              cs_idx = 2'h0;
            end
          endcase
        end
      end
      CBMD_BM_MIN512,
      CBMD_BM_MAX512:
      begin
        // Released window starts at zero, internal window above the
        // internal program area; each select is a 512K slice.
        if (st_r.released)
        begin
          ext_hit = (addr < CBMD_REL_EXT_TOP);
        end
        else
        begin
          ext_hit = (addr >= CBMD_INT_EXT_BOT) &&
                    (addr < CBMD_INT_EXT_TOP);
        end
        cs_idx = addr[20:19];
      end
      default:
      begin
        ext_hit = 1'b0;
      end
    endcase
    // Internal memory always wins an overlap.
    ext_hit = ext_hit && !int_page && !prom_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_nxt = st_r;

    // The strap is taken once, after the synchroniser has filled and its
    // last two stages agree; a later pin change needs a new reset.
    if (!st_r.strapped)
    begin
      if (st_r.settle != CBMD_SETTLE_CNT)
      begin
        st_nxt.settle = st_r.settle + 2'h1;
      end
      else if (pin_agree)
      begin
        st_nxt.strapped = 1'b1;
        st_nxt.released = !pin_level;
        st_nxt.bus_mode = pin_level ? CBMD_BM_SINGLE
                                    : CBMD_BM_EXP64;
      end
    end
    else if (bus_mode_wr_i)
    begin
      // Requests that the program mode forbids leave the mode unchanged.
      st_nxt.cs_size = cs_size_i;
      unique case (bus_mode_sel_i)
        CBMD_SEL_SINGLE:
        begin
          if (!st_r.released)
          begin
            st_nxt.bus_mode = CBMD_BM_SINGLE;
          end
        end
        CBMD_SEL_EXP64:
        begin
          if (st_r.released)
          begin
            st_nxt.bus_mode = CBMD_BM_EXP64;
          end
        end
        CBMD_SEL_MIN512:
        begin
          st_nxt.bus_mode = CBMD_BM_MIN512;
        end
        default:
        begin
          st_nxt.bus_mode = CBMD_BM_MAX512;
        end
      endcase
    end

    // Strobes follow the request one cycle later and only for an external
    // target; internal accesses leave them idle and, outside single chip, the data lines free.
    st_nxt.int_sel = access && !ext_hit;
    st_nxt.cs_n = {CBMD_CS_N{1'b1}};
    st_nxt.rd_n = 1'b1;
    st_nxt.wr_n = 1'b1;
    st_nxt.dat_oe = 8'h00;
    st_nxt.dat_out = cpu_wdata_i;
    if (access && ext_hit)
    begin
      st_nxt.cs_n[cs_idx] = 1'b0;
      st_nxt.rd_n = !cpu_rd_i;
      st_nxt.wr_n = !(cpu_wr_i && !cpu_rd_i);
      if (cpu_wr_i && !cpu_rd_i)
      begin
        st_nxt.dat_oe = 8'hFF;
      end
    end
    if (st_r.bus_mode == CBMD_BM_SINGLE)
    begin
      // Data lines are plain bidirectional port bits here.
      st_nxt.dat_out = port_data_i;
      st_nxt.dat_oe = port_dir_i;
    end

    // Read data is taken while the registered read strobe st_r.rd_n is low, not the single-chip port pin.
    if (!st_r.rd_n)
    begin
      st_nxt.rdata = external_data_lines_i;
    end

    unique case (st_r.bus_mode)
      CBMD_BM_SINGLE:
      begin
        st_nxt.addr_pin = port_out_i[CBMD_PIN_ADDR_W-1:0];
      end
      CBMD_BM_EXP64:
      begin
        st_nxt.addr_pin = {port_out_i[CBMD_PIN_ADDR_W-1:16], addr[15:0]};
      end
      default:
      begin
        st_nxt.addr_pin = addr[CBMD_PIN_ADDR_W-1:0];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= CBMD_STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin muxing. The strobes come from flip-flops; in single chip every
  // shared pin reflects the port registers instead.

  logic single;

  assign single = (st_r.bus_mode == CBMD_BM_SINGLE);

  assign addr_pin_o = st_r.addr_pin;
  assign rd_n_pin_o = single ? port_out_i[CBMD_PORT_RD] : st_r.rd_n;
  assign wr_n_pin_o = single ? port_out_i[CBMD_PORT_WR] : st_r.wr_n;

  genvar gi;
  generate
    for (gi = 0; gi < CBMD_CS_N; gi++)
    begin : g_cs
      assign cs_n_pin_o[gi] = (single || !cs_pin_en_i[gi])
                            ? port_out_i[CBMD_PORT_CS_LSB + gi]
                            : st_r.cs_n[gi];
    end
  endgenerate

  assign gp_port_o = port_out_i[CBMD_PORT_W-1:CBMD_PORT_GP_LSB];

  // Pull-ups hold each data line whenever it is not driven.
  assign external_data_lines_o = st_r.dat_out;
  assign external_data_lines_oe_o = st_r.dat_oe;
  assign external_data_lines_pu_o = ~st_r.dat_oe;

  assign cpu_rdata_o = st_r.rdata;
  assign cpu_int_sel_o = st_r.int_sel;
  assign mode_ready_o = st_r.strapped;
  assign released_program_mode_o = st_r.released;
  assign bus_ports_mode_o = single;

  // Only the maximum mode lets the core leave the common area plus one bank.
  assign core_max_model_o = (st_r.bus_mode == CBMD_BM_MAX512);

  always_comb
  begin
    unique case (st_r.bus_mode)
      CBMD_BM_SINGLE: bus_mode_o = CBMD_SEL_SINGLE;
      CBMD_BM_EXP64: bus_mode_o = CBMD_SEL_EXP64;
      CBMD_BM_MIN512: bus_mode_o = CBMD_SEL_MIN512;
      default: bus_mode_o = CBMD_SEL_MAX512;
    endcase
  end

endmodule // cbmd_top

// *** tb/cbmd_assertions.sv ***
// Concurrent checks on the ports of the mode decoder top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
module cbmd_chk
  import cbmd_pkg::*;
#(
  parameter int unsigned ADDR_W = CBMD_ADDR_W
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic mode_pin_pullup_en_o,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_int_sel_o,
  input wire logic bus_mode_wr_i,
  input wire logic [1:0] bus_mode_sel_i,
  input wire logic [1:0] cs_size_i,
  input wire logic [CBMD_CS_N-1:0] cs_pin_en_i,
  input wire logic mode_ready_o,
  input wire logic released_program_mode_o,
  input wire logic [1:0] bus_mode_o,
  input wire logic bus_ports_mode_o,
  input wire logic rd_n_pin_o,
  input wire logic wr_n_pin_o,
  input wire logic [CBMD_CS_N-1:0] cs_n_pin_o,
  input wire logic [7:0] external_data_lines_o,
  input wire logic [7:0] external_data_lines_oe_o
);
  ////////////////////////////////////////
  logic req;
  logic page;
  logic win;
  logic [3:0] cs_exp;
  logic bad_sel;
  logic [1:0] sz_r;
  // Mirrors the select size so that the gap above 007FFFH in 8K mode is left out.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sz_r <= CBMD_SZ_RST;
    end
    else if (mode_ready_o && bus_mode_wr_i)
    begin
      sz_r <= cs_size_i;
    end
  end
  assign req = mode_ready_o && (cpu_rd_i || cpu_wr_i);
  assign page = cpu_addr_i[21:12] == CBMD_INT_PAGE;
  // The 512K window moves with the strap, and the page always wins.
  assign win = !page && (released_program_mode_o ?
    cpu_addr_i < CBMD_REL_EXT_TOP :
    cpu_addr_i >= CBMD_INT_EXT_BOT && cpu_addr_i < CBMD_INT_EXT_TOP);
  assign cs_exp = ~(4'h1 << cpu_addr_i[20:19]);
  assign bad_sel = released_program_mode_o ?
    bus_mode_sel_i == CBMD_SEL_SINGLE : bus_mode_sel_i == CBMD_SEL_EXP64;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////
  a_pullup_on: assert property (mode_pin_pullup_en_o)
    else $error("strap pull-up off");
  a_page_inside: assert property (req && page && !bus_ports_mode_o
    |=> cpu_int_sel_o && rd_n_pin_o && wr_n_pin_o && &cs_n_pin_o)
    else $error("internal page went outside");
  a_prom_inside: assert property (req && !released_program_mode_o
    && cpu_addr_i < CBMD_PROM_TOP |=> cpu_int_sel_o && (bus_ports_mode_o
    || external_data_lines_oe_o == 8'h00 && &cs_n_pin_o))
    else $error("program memory access went outside");
  a_exp_write: assert property (req && cpu_wr_i && !cpu_rd_i
    && bus_mode_o == CBMD_SEL_EXP64 && cpu_addr_i < CBMD_PROM_TOP
    && (sz_r != CBMD_SZ_8K || !cpu_addr_i[15])
    |=> !wr_n_pin_o && external_data_lines_oe_o == 8'hFF
    && external_data_lines_o == $past(cpu_wdata_i))
    else $error("external write not driven");
  a_win_read: assert property (req && cpu_rd_i && bus_mode_o[1]
    |=> rd_n_pin_o == !$past(win))
    else $error("512K window read strobe wrong");
  a_cs_fixed: assert property (req && cpu_rd_i && bus_mode_o[1] && win
    && &cs_pin_en_i |=> cs_n_pin_o == $past(cs_exp))
    else $error("512K select wrong");
  a_mode_refused: assert property (mode_ready_o && bus_mode_wr_i
    && bad_sel |=> $stable(bus_mode_o))
    else $error("forbidden bus mode taken");
  a_strap_hold: assert property (mode_ready_o
    |=> mode_ready_o && $stable(released_program_mode_o))
    else $error("strap changed without reset");
  a_boot_mode: assert property ($rose(mode_ready_o) |=> bus_mode_o ==
    (released_program_mode_o ? CBMD_SEL_EXP64 : CBMD_SEL_SINGLE))
    else $error("wrong bus mode after reset");
endmodule // cbmd_chk

bind cbmd_top cbmd_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** tb/cbmd_ext_mem.sv ***
// Behavioural external memory on the expansion bus.
// Assumes active-low selects and strobes; idle data lines are pulled up.
`timescale 1ns/10ps
module cbmd_ext_mem (
  input wire logic core_clk_i,
  input wire logic [18:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] cs_n_i,
  input wire logic [7:0] dev_d_i,
  input wire logic [7:0] dev_oe_i,
  output logic [7:0] line_o
);
  logic [7:0] mem_r [0:255];
  logic [7:0] idx;
  logic drive;
  assign idx = {~cs_n_i, addr_i[3:0]};
  // Answers only while selected and read, so vectors come from here.
  assign drive = !rd_n_i && !(&cs_n_i);
  // Undriven lines show the pull-up level, never a stale value.
  assign line_o = (dev_oe_i & dev_d_i) |
    (~dev_oe_i & (drive ? mem_r[idx] : 8'hFF));
  always_ff @(posedge core_clk_i)
    if (!wr_n_i && !(&cs_n_i))
      mem_r[idx] <= dev_d_i;
endmodule // cbmd_ext_mem

// *** tb/cbmd_tb_top.sv ***
// Self-checking bench for the mode decoder with an external memory.
// Assumes the package constants and a 25 MHz core clock.
`timescale 1ns/10ps
module cbmd_tb_top;
  import cbmd_pkg::*;
  logic core_clk_i, arst_n_i, program_source_select_pin_i;
  logic cpu_rd_i, cpu_wr_i, bus_mode_wr_i, mode_pin_pullup_en_o;
  logic cpu_int_sel_o, mode_ready_o, released_program_mode_o;
  logic core_max_model_o, bus_ports_mode_o, rd_n_pin_o, wr_n_pin_o;
  logic [21:0] cpu_addr_i;
  logic [7:0] cpu_wdata_i, cpu_rdata_o, port_data_i, port_dir_i;
  logic [7:0] external_data_lines_i, external_data_lines_o;
  logic [7:0] external_data_lines_oe_o, external_data_lines_pu_o;
  logic [1:0] bus_mode_sel_i, cs_size_i, bus_mode_o;
  logic [3:0] cs_pin_en_i, cs_n_pin_o;
  logic [33:0] port_out_i;
  logic [18:0] addr_pin_o;
  logic [8:0] gp_port_o;
  int fail_count = 0;
  int cmp_count = 0;

  cbmd_top dut (.*);
  cbmd_ext_mem u_mem (
    .core_clk_i(core_clk_i),
    .addr_i(addr_pin_o),
    .rd_n_i(rd_n_pin_o),
    .wr_n_i(wr_n_pin_o),
    .cs_n_i(cs_n_pin_o),
    .dev_d_i(external_data_lines_o),
    .dev_oe_i(external_data_lines_oe_o),
    .line_o(external_data_lines_i)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic boot(input logic pin);
    int n;
    @(posedge core_clk_i);
    program_source_select_pin_i <= pin;
    arst_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (n = 0; n < 20 && mode_ready_o !== 1'b1; n++)
    begin
      @(posedge core_clk_i);
      #1;
    end
    chk(mode_ready_o, 1'b1);
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic setm(input logic [1:0] s, input logic [1:0] z);
    @(posedge core_clk_i);
    bus_mode_wr_i <= 1'b1;
    bus_mode_sel_i <= s;
    cs_size_i <= z;
    @(posedge core_clk_i);
    bus_mode_wr_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask

  // One request cycle; returns just after the strobes have landed.
  task automatic acc(input logic [21:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk_i);
    cpu_addr_i <= a;
    cpu_rd_i <= !w;
    cpu_wr_i <= w;
    cpu_wdata_i <= d;
    @(posedge core_clk_i);
    cpu_rd_i <= 1'b0;
    cpu_wr_i <= 1'b0;
    #1;
  endtask

  task automatic int_acc(input logic [21:0] a, input logic w, input logic p);
    acc(a, w, 8'hC3);
    chk({cs_n_pin_o, rd_n_pin_o, wr_n_pin_o}, p ?
      {port_out_i[24:21], port_out_i[19], port_out_i[20]} : 6'h3F);
    chk({external_data_lines_pu_o, external_data_lines_i}, 16'hFFFF);
  endtask

  task automatic ext_wr(input logic [21:0] a, input logic [7:0] d,
                        input logic [3:0] cs);
    acc(a, 1'b1, d);
    chk({cs_n_pin_o, wr_n_pin_o, external_data_lines_oe_o}, {cs, 9'h0FF});
    chk({addr_pin_o[15:0], external_data_lines_o}, {a[15:0], d});
  endtask

  task automatic ext_rd(input logic [21:0] a, input logic [3:0] cs,
                        input logic [7:0] d);
    acc(a, 1'b0, 8'h00);
    chk({cs_n_pin_o, rd_n_pin_o, external_data_lines_oe_o}, {cs, 9'h000});
    @(posedge core_clk_i);
    #1;
    chk(cpu_rdata_o, d);
  endtask
  ////////////////////////////////////////
  task automatic t_internal;
    boot(1'b1);
    chk({released_program_mode_o, mode_pin_pullup_en_o}, 2'h1);
    chk({bus_mode_o, bus_ports_mode_o}, {CBMD_SEL_SINGLE, 1'b1});
    chk(gp_port_o, port_out_i[33:25]);
    int_acc(22'h00_0000, 1'b0, 1'b1);
    chk(cpu_int_sel_o, 1'b1);
    // Data lines act as port bits with their own direction in single chip.
    @(posedge core_clk_i);
    port_dir_i <= 8'hF0;
    port_data_i <= 8'h5A;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({external_data_lines_pu_o, external_data_lines_oe_o,
      external_data_lines_o}, 24'h0F_F05A);
    setm(CBMD_SEL_EXP64, CBMD_SZ_8K);
    chk(bus_mode_o, CBMD_SEL_SINGLE);
    setm(CBMD_SEL_MAX512, CBMD_SZ_64K);
    chk({bus_mode_o, core_max_model_o}, {CBMD_SEL_MAX512, 1'b1});
    int_acc(22'h00_8000, 1'b0, 1'b0);
    int_acc(22'h00_F100, 1'b1, 1'b0);
    int_acc(22'h07_FFFF, 1'b0, 1'b0);
    ext_wr(22'h20_0005, 8'hA5, 4'hE);
    ext_rd(22'h20_0005, 4'hE, 8'hA5);
    ext_wr(22'h08_0000, 8'h69, 4'hD);
    ext_wr(22'h1F_FFF3, 8'h5A, 4'h7);
    ext_rd(22'h1F_FFF3, 4'h7, 8'h5A);
    @(posedge core_clk_i);
    program_source_select_pin_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk(released_program_mode_o, 1'b0);
    $display("internal program test done");
  endtask

  task automatic t_released;
    logic [21:0] a [4] = '{22'h00_2000, 22'h00_4000, 22'h00_8000, 22'h00_8000};
    logic [3:0] cs [4] = '{4'hD, 4'hD, 4'hD, 4'hE};
    boot(1'b0);
    chk({released_program_mode_o, bus_mode_o}, {1'b1, CBMD_SEL_EXP64});
    setm(CBMD_SEL_SINGLE, CBMD_SZ_8K);
    chk({bus_mode_o, bus_ports_mode_o}, {CBMD_SEL_EXP64, 1'b0});
    ext_wr(22'h00_0000, 8'h12, 4'hE);
    ext_rd(22'h00_0000, 4'hE, 8'h12);
    ext_wr(22'h00_6000, 8'h34, 4'h7);
    for (int i = 0; i < 4; i++)
    begin
      setm(CBMD_SEL_EXP64, i[1:0]);
      ext_wr(a[i], 8'h40 + i[7:0], cs[i]);
    end
    int_acc(22'h00_F000, 1'b0, 1'b0);
    int_acc(22'h00_FFFF, 1'b1, 1'b0);
    setm(CBMD_SEL_MIN512, CBMD_SZ_8K);
    chk({bus_mode_o, core_max_model_o}, {CBMD_SEL_MIN512, 1'b0});
    ext_wr(22'h1F_FFFF, 8'h77, 4'h7);
    int_acc(22'h20_0000, 1'b0, 1'b0);
    int_acc(22'h00_F7FF, 1'b1, 1'b0);
    $display("released program test done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #400_000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    arst_n_i = 1'b0;
    program_source_select_pin_i = 1'b1;
    {cpu_rd_i, cpu_wr_i, bus_mode_wr_i} = 3'h0;
    cpu_addr_i = 22'h00_0000;
    cpu_wdata_i = 8'h00;
    {bus_mode_sel_i, cs_size_i} = 4'h0;
    cs_pin_en_i = 4'hF;
    // Port select bits stay high so the memory never answers in single chip.
    port_out_i = 34'h1_55F5_5555;
    {port_data_i, port_dir_i} = 16'h0000;
    t_internal();
    t_released();
    end_of_test();
  end
endmodule // cbmd_tb_top
